/* hdl/dlmtg_top.sv */
// Added by the designer: the address map and the APB interface to the registers.
`include "dlmtg_map.svh"
module dlmtg_top #(
  parameter int BOOT_CYCLES = `DLMTG_BOOT_MS * `DLMTG_CLK_MHZ * 1000,
  parameter int SEC_CYCLES  = `DLMTG_CLK_MHZ * 1000000
) (
  // clock and reset
  input  wire  logic                  clock_in,
  input  wire  logic                  rst_n_in,
  input  wire  logic                  clk_en_in,
  // apb slave
  input  wire  logic                  psel_in,
  input  wire  logic                  penable_in,
  input  wire  logic                  pwrite_in,
  input  wire  logic [11:0]           paddr_in,
  input  wire  logic [31:0]           pwdata_in,
  output logic       [31:0]           prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  // vehicle side
  input  wire  logic                  key_on_in,
  input  wire  logic                  brake_released_in,
  input  wire  logic                  battery_ok_in,
  input  wire  logic [6:0]            vehicle_speed_in,
  input  wire  dlmtg_pkg::dlmtg_demand_t throttle_in,
  input  wire  logic [15:0]           wiper_ohm_in,
  input  wire  logic [7:0]            motor_amp_in,
  input  wire  logic [7:0]            peak_limit_in,
  input  wire  logic [7:0]            other_limit_in,
  // power stage side
  output dlmtg_pkg::dlmtg_demand_t    demand_out,
  output logic [6:0]                  speed_cap_out,
  output logic [7:0]                  current_limit_out,
  output logic                        wake_out,
  output logic                        motion_ctrl_out,
  output logic                        irq_out
);
  import dlmtg_pkg::*;

  logic              wiper_en_r, prot_en_r;
  logic [6:0]        roll_pct_r;
  dlmtg_wiper_t      wiper_r;
  logic [6:0]        oem_fmax_r, oem_rmax_r, oem_flow_r, oem_rlow_r;
  logic [6:0]        oem_acc_r, oem_dec_r;
  logic [6:0]        fmax_r, rmax_r, flow_r, rlow_r;
  logic [6:0]        facc_r, racc_r, fdec_r, rdec_r;
  logic [7:0]        cont_r, heat_s_r;
  logic [9:0]        cool_s_r;
  logic [3:0]        irq_stat_r, irq_mask_r;
  logic [3:0]        evt;
  dlmtg_roll_t       roll_r;
  logic [31:0]       boot_cnt_r;
  logic              hot_r;
  logic [47:0]       heat_acc_r;
  logic [47:0]       cool_cnt_r;
  logic              wr, rd_ok;
  logic              rejected;

  assign wr          = psel_in & penable_in & pwrite_in & clk_en_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~rd_ok;

  function automatic logic [6:0] pct(input logic [31:0] v);
    pct = (v[6:0] > `DLMTG_PCT_FULL) ? `DLMTG_PCT_FULL : v[6:0];
  endfunction

  // configuration writes; out-of-bound dealer speed values leave old value, acceleration values are clamped
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      wiper_en_r <= 1'b0;
      prot_en_r  <= 1'b0;
      roll_pct_r <= `DLMTG_ROLL_DEF;
      wiper_r    <= {4{`DLMTG_WIPER_DEF}};
      oem_fmax_r <= `DLMTG_PCT_FULL;
      oem_rmax_r <= `DLMTG_PCT_FULL;
      oem_flow_r <= 7'h00;
      oem_rlow_r <= 7'h00;
      oem_acc_r  <= `DLMTG_PCT_FULL;
      oem_dec_r  <= `DLMTG_PCT_FULL;
      fmax_r     <= `DLMTG_PCT_FULL;
      rmax_r     <= `DLMTG_PCT_FULL;
      flow_r     <= 7'h00;
      rlow_r     <= 7'h00;
      {facc_r, racc_r, fdec_r, rdec_r} <= {4{`DLMTG_PCT_FULL}};
      cont_r     <= `DLMTG_CONT_DEF;
      heat_s_r   <= `DLMTG_HEAT_DEF;
      cool_s_r   <= `DLMTG_COOL_DEF;
      irq_mask_r <= 4'h0;
    end
    else if (wr)
    begin
      case (paddr_in)
        `DLMTG_A_CTRL:
        begin
          wiper_en_r <= pwdata_in[0];
          prot_en_r  <= pwdata_in[1];
        end
        `DLMTG_A_ROLL:
          roll_pct_r <= (pct(pwdata_in) < `DLMTG_ROLL_MIN) ?
                        `DLMTG_ROLL_MIN : pct(pwdata_in);
        `DLMTG_A_WIPER:
          wiper_r <= {pct(pwdata_in),
                      pct({25'h0, pwdata_in[14:8]}),
                      pct({25'h0, pwdata_in[22:16]}),
                      pct({25'h0, pwdata_in[30:24]})};
        `DLMTG_A_OEM_SPD:
        begin
          oem_fmax_r <= pct({25'h0, pwdata_in[30:24]});
          oem_rmax_r <= pct({25'h0, pwdata_in[22:16]});
          oem_flow_r <= (pwdata_in[14:8] > `DLMTG_FWD_LOW_MAX) ?
                        `DLMTG_FWD_LOW_MAX : pwdata_in[14:8];
          oem_rlow_r <= pct(pwdata_in);
        end
        `DLMTG_A_OEM_ACC:
        begin
          oem_acc_r <= pct({25'h0, pwdata_in[14:8]});
          oem_dec_r <= pct(pwdata_in);
        end
        `DLMTG_A_DEALER0:
        begin
          if (pct({25'h0, pwdata_in[30:24]}) <= oem_fmax_r)
            fmax_r <= pct({25'h0, pwdata_in[30:24]});
          if (pct({25'h0, pwdata_in[22:16]}) <= oem_rmax_r)
            rmax_r <= pct({25'h0, pwdata_in[22:16]});
          if (pct({25'h0, pwdata_in[14:8]}) >= oem_flow_r)
            flow_r <= pct({25'h0, pwdata_in[14:8]});
          if (pct(pwdata_in) >= oem_rlow_r)
            rlow_r <= pct(pwdata_in);
        end
        `DLMTG_A_DEALER1:
        begin
          // acceleration values are clamped rather than refused
          facc_r <= (pct({25'h0, pwdata_in[30:24]}) > oem_acc_r) ?
                    oem_acc_r : pct({25'h0, pwdata_in[30:24]});
          racc_r <= (pct({25'h0, pwdata_in[22:16]}) > oem_acc_r) ?
                    oem_acc_r : pct({25'h0, pwdata_in[22:16]});
          fdec_r <= (pct({25'h0, pwdata_in[14:8]}) > oem_dec_r) ?
                    oem_dec_r : pct({25'h0, pwdata_in[14:8]});
          rdec_r <= (pct(pwdata_in) > oem_dec_r) ?
                    oem_dec_r : pct(pwdata_in);
        end
        `DLMTG_A_MOTOR:
        begin
          cont_r   <= pwdata_in[7:0];
          heat_s_r <= pwdata_in[15:8];
        end
        `DLMTG_A_COOL:
          cool_s_r <= pwdata_in[9:0];
        `DLMTG_A_IRQ_MASK:
          irq_mask_r <= pwdata_in[3:0];
        default:
          irq_mask_r <= irq_mask_r;
      endcase
    end
  end

  assign rejected = wr && (paddr_in == `DLMTG_A_DEALER0) &&
    ((pct({25'h0, pwdata_in[30:24]}) > oem_fmax_r) ||
     (pct({25'h0, pwdata_in[22:16]}) > oem_rmax_r) ||
     (pct({25'h0, pwdata_in[14:8]}) < oem_flow_r) ||
     (pct(pwdata_in) < oem_rlow_r));

  // roll-away guard; battery absence does not change the behaviour
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      roll_r     <= DLMTG_ASLEEP;
      boot_cnt_r <= 32'h0;
    end
    else if (clk_en_in)
    begin
      case (roll_r)
        DLMTG_ASLEEP:
          if (!key_on_in && brake_released_in &&
              vehicle_speed_in > roll_pct_r)
          begin
            roll_r     <= DLMTG_BOOT;
            boot_cnt_r <= 32'h0;
          end
        DLMTG_BOOT:
          if (boot_cnt_r == BOOT_CYCLES - 1)
            roll_r <= DLMTG_GUARD;
          else
            boot_cnt_r <= boot_cnt_r + 32'h1;
        DLMTG_GUARD:
          if (key_on_in || !brake_released_in)
            roll_r <= DLMTG_ASLEEP;
        default:
          roll_r <= DLMTG_ASLEEP;
      endcase
    end
  end

  assign wake_out        = (roll_r != DLMTG_ASLEEP);
  assign motion_ctrl_out = key_on_in ? 1'b1 : (roll_r == DLMTG_GUARD);

  // wiper factor: 0 at zero ohms, 100 at full resistance and above
  logic [6:0]  wfrac;
  logic [6:0]  lim_f, lim_r, scl_f, scl_r;
  logic [13:0] scaled;
  logic [6:0]  dir_max, cap;

  assign wfrac = (wiper_ohm_in >= `DLMTG_WIPER_FULL) ? `DLMTG_PCT_FULL :
                 7'((32'(wiper_ohm_in) * 100) / 32'(`DLMTG_WIPER_FULL));

  function automatic logic [6:0] blend(input logic [6:0] s,
                                       input logic [6:0] f);
    // linear from setting at zero ohms to full at the top
    blend = 7'(32'(s) + ((32'(`DLMTG_PCT_FULL) - 32'(s)) * 32'(f)) / 100);
  endfunction

  always_comb
  begin
    lim_f = `DLMTG_PCT_FULL;
    lim_r = `DLMTG_PCT_FULL;
    scl_f = `DLMTG_PCT_FULL;
    scl_r = `DLMTG_PCT_FULL;
    if (wiper_en_r)
    begin
      lim_f = blend(wiper_r.fwd_limit, wfrac);
      lim_r = blend(wiper_r.rev_limit, wfrac);
      scl_f = blend(wiper_r.fwd_scale, wfrac);
      scl_r = blend(wiper_r.rev_scale, wfrac);
    end
  end

  assign scaled  = 14'(throttle_in.speed_pct) *
                   14'(throttle_in.reverse ? scl_r : scl_f);
  assign dir_max = throttle_in.reverse ? rmax_r : fmax_r;
  assign cap     = throttle_in.reverse ?
                   ((lim_r < rmax_r) ? lim_r : rmax_r) :
                   ((lim_f < fmax_r) ? lim_f : fmax_r);

  // thermal model: each cycle of excess current while not hot adds motor_amp_in minus cont_r
  logic [47:0] heat_full;
  logic        hot_enter;
  assign heat_full = 48'(peak_limit_in > cont_r ?
                     peak_limit_in - cont_r : 8'h0) *
                     48'(heat_s_r) * 48'(SEC_CYCLES);
  assign hot_enter = prot_en_r && !hot_r && heat_acc_r >= heat_full;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      hot_r      <= 1'b0;
      heat_acc_r <= 48'h0;
      cool_cnt_r <= 48'h0;
    end
    else if (clk_en_in)
    begin
      if (!prot_en_r)
      begin
        hot_r      <= 1'b0;
        heat_acc_r <= 48'h0;
        cool_cnt_r <= 48'h0;
      end
      else if (!hot_r)
      begin
        if (hot_enter)
        begin
          hot_r      <= 1'b1;
          cool_cnt_r <= 48'h0;
        end
        else if (motor_amp_in > cont_r)
          heat_acc_r <= heat_acc_r + 48'(motor_amp_in - cont_r);
      end
      else if (motor_amp_in >= cont_r)
        cool_cnt_r <= 48'h0;
      else if (cool_cnt_r >= 48'(cool_s_r) * 48'(SEC_CYCLES))
      begin
        hot_r      <= 1'b0;
        heat_acc_r <= 48'h0;
      end
      else
        cool_cnt_r <= cool_cnt_r + 48'h1;
    end
  end

  // demand, speed cap and current limit outputs registered
  logic [7:0] prot_lim, lim_min;
  assign prot_lim = hot_r ? cont_r : peak_limit_in;
  assign lim_min  = (prot_lim < other_limit_in) ?
                    prot_lim : other_limit_in;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      demand_out        <= '0;
      speed_cap_out     <= 7'h00;
      current_limit_out <= 8'h00;
    end
    else if (clk_en_in)
    begin
      demand_out.reverse   <= throttle_in.reverse;
      demand_out.speed_pct <= (roll_r == DLMTG_GUARD && !key_on_in) ?
                              7'h00 : 7'(scaled / 14'd100);
      speed_cap_out        <= (!key_on_in && roll_r == DLMTG_GUARD) ?
                              ((roll_pct_r < cap) ? roll_pct_r : cap) :
                              ((dir_max < cap) ? dir_max : cap);
      current_limit_out    <= lim_min;
    end
  end

  // interrupts: set wins over write-one clear
  assign evt[`DLMTG_IRQ_WAKE] = clk_en_in && roll_r == DLMTG_ASLEEP &&
    !key_on_in && brake_released_in && vehicle_speed_in > roll_pct_r;
  assign evt[`DLMTG_IRQ_REJ]  = rejected;
  assign evt[`DLMTG_IRQ_HOT]  = clk_en_in && hot_enter;
  assign evt[`DLMTG_IRQ_COOL] = clk_en_in && hot_r && prot_en_r &&
    motor_amp_in < cont_r && cool_cnt_r >= 48'(cool_s_r) * 48'(SEC_CYCLES);

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      irq_stat_r <= 4'h0;
    else if (clk_en_in)
      irq_stat_r <= (irq_stat_r & ~((wr && paddr_in == `DLMTG_A_IRQ_STAT) ?
                    pwdata_in[3:0] : 4'h0)) | evt;
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  always_comb
  begin
    rd_ok      = 1'b1;
    prdata_out = 32'h0;
    case (paddr_in)
      `DLMTG_A_CTRL:     prdata_out = {30'h0, prot_en_r, wiper_en_r};
      `DLMTG_A_ROLL:     prdata_out = {25'h0, roll_pct_r};
      `DLMTG_A_WIPER:    prdata_out = {1'b0, wiper_r.rev_scale, 1'b0,
                           wiper_r.fwd_scale, 1'b0, wiper_r.rev_limit,
                           1'b0, wiper_r.fwd_limit};
      `DLMTG_A_OEM_SPD:  prdata_out = {1'b0, oem_fmax_r, 1'b0, oem_rmax_r,
                           1'b0, oem_flow_r, 1'b0, oem_rlow_r};
      `DLMTG_A_OEM_ACC:  prdata_out = {17'h0, oem_acc_r, 1'b0, oem_dec_r};
      `DLMTG_A_DEALER0:  prdata_out = {1'b0, fmax_r, 1'b0, rmax_r,
                           1'b0, flow_r, 1'b0, rlow_r};
      `DLMTG_A_DEALER1:  prdata_out = {1'b0, facc_r, 1'b0, racc_r,
                           1'b0, fdec_r, 1'b0, rdec_r};
      `DLMTG_A_MOTOR:    prdata_out = {16'h0, heat_s_r, cont_r};
      `DLMTG_A_COOL:     prdata_out = {22'h0, cool_s_r};
      `DLMTG_A_STATUS:   prdata_out = {28'h0, hot_r, motion_ctrl_out,
                           roll_r};
      `DLMTG_A_IRQ_STAT: prdata_out = {28'h0, irq_stat_r};
      `DLMTG_A_IRQ_MASK: prdata_out = {28'h0, irq_mask_r};
      `DLMTG_A_LIMITS:   prdata_out = {17'h0, current_limit_out,
                           speed_cap_out};
      default:           rd_ok = 1'b0;
    endcase
  end
endmodule

/* hdl/dlmtg_map.svh */
`ifndef DLMTG_MAP_SVH
`define DLMTG_MAP_SVH
`define DLMTG_A_CTRL      12'h000
`define DLMTG_A_ROLL      12'h004
`define DLMTG_A_WIPER     12'h008
`define DLMTG_A_OEM_SPD   12'h00C
`define DLMTG_A_OEM_ACC   12'h010
`define DLMTG_A_DEALER0   12'h014
`define DLMTG_A_DEALER1   12'h018
`define DLMTG_A_MOTOR     12'h01C
`define DLMTG_A_COOL      12'h020
`define DLMTG_A_STATUS    12'h024
`define DLMTG_A_IRQ_STAT  12'h028
`define DLMTG_A_IRQ_MASK  12'h02C
`define DLMTG_A_LIMITS    12'h030
`define DLMTG_ROLL_DEF    7'd40
`define DLMTG_ROLL_MIN    7'd30
`define DLMTG_PCT_FULL    7'd100
`define DLMTG_WIPER_DEF   7'd50
`define DLMTG_FWD_LOW_MAX 7'd10
`define DLMTG_CONT_DEF    8'd12
`define DLMTG_HEAT_DEF    8'd20
`define DLMTG_COOL_DEF    10'd32
`define DLMTG_WIPER_FULL  16'd10000
`define DLMTG_BOOT_MS     2000
`define DLMTG_CLK_MHZ     200
`define DLMTG_IRQ_WAKE    0
`define DLMTG_IRQ_REJ     1
`define DLMTG_IRQ_HOT     2
`define DLMTG_IRQ_COOL    3
`endif

/* hdl/dlmtg_pkg.sv */
package dlmtg_pkg;
  typedef enum logic [1:0] {DLMTG_ASLEEP, DLMTG_BOOT, DLMTG_GUARD}
    dlmtg_roll_t;
  typedef struct packed {
    logic [6:0] fwd_limit;
    logic [6:0] rev_limit;
    logic [6:0] fwd_scale;
    logic [6:0] rev_scale;
  } dlmtg_wiper_t;
  typedef struct packed {
    logic [6:0] speed_pct;
    logic       reverse;
  } dlmtg_demand_t;
endpackage

/* tb/dlmtg_stage_model.sv */
module dlmtg_stage_model (
  // clock
  input  wire logic       clock_in,
  // bench request and block limit
  input  wire logic [7:0] amp_req_in,
  input  wire logic [7:0] current_limit_in,
  // measured current
  output logic      [7:0] motor_amp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // the stage obeys the limit one cycle late, like a real current loop
  always_ff @(posedge clock_in)
  begin
    if (amp_req_in < current_limit_in)
      motor_amp_out <= amp_req_in;
    else
      motor_amp_out <= current_limit_in;
  end
endmodule

/* tb/dlmtg_top_props.sv */
module dlmtg_top_chk #(
  parameter int BOOT_CYCLES = 20
) (
  // clock and reset
  input wire logic                     clock_in,
  input wire logic                     rst_n_in,
  input wire logic                     clk_en_in,
  // apb
  input wire logic                     psel_in,
  input wire logic                     penable_in,
  input wire logic [11:0]              paddr_in,
  input wire logic [31:0]              prdata_out,
  input wire logic                     pslverr_out,
  // vehicle and power stage side
  input wire logic                     key_on_in,
  input wire logic                     brake_released_in,
  input wire logic [6:0]               vehicle_speed_in,
  input wire dlmtg_pkg::dlmtg_demand_t throttle_in,
  input wire logic [7:0]               other_limit_in,
  input wire dlmtg_pkg::dlmtg_demand_t demand_out,
  input wire logic [6:0]               speed_cap_out,
  input wire logic [7:0]               current_limit_out,
  input wire logic                     wake_out,
  input wire logic                     motion_ctrl_out,
  input wire logic                     irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dlmtg_pkg::*;
  int unsigned boot_cnt_r;
  logic        guard;
  assign guard = wake_out && motion_ctrl_out && !key_on_in;
  default clocking dcb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  // saturates so the guard phase cannot wrap the count
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || !wake_out)
      boot_cnt_r <= 0;
    else if (clk_en_in && boot_cnt_r < BOOT_CYCLES)
      boot_cnt_r <= boot_cnt_r + 1;
  end
  chk_wake_cause: assert property (
    $rose(wake_out) |-> $past(!key_on_in && brake_released_in))
    else $error("wake without key off and brake released");
  chk_wake_speed: assert property (
    $rose(wake_out) |-> $past(vehicle_speed_in) > 7'h1E)
    else $error("wake at or below lowest roll speed");
  chk_boot_idle: assert property (
    wake_out && !key_on_in && boot_cnt_r < BOOT_CYCLES - 1
      |-> !motion_ctrl_out)
    else $error("motion control during boot");
  chk_guard_stop: assert property (
    guard [*2] |-> demand_out.speed_pct == 7'h00)
    else $error("demand not zero in guard");
  chk_guard_cap: assert property (
    guard [*2] |-> speed_cap_out >= 7'h1E && speed_cap_out <= 7'h64)
    else $error("guard cap outside roll range");
  chk_guard_exit: assert property (
    guard ##1 (key_on_in || !brake_released_in) && clk_en_in |=> !wake_out)
    else $error("guard kept after key on or brake");
  chk_limit_min: assert property (
    $past(clk_en_in) && $past(rst_n_in)
      |-> current_limit_out <= $past(other_limit_in))
    else $error("current limit above other request");
  chk_scale_down: assert property (
    $past(clk_en_in) && $past(rst_n_in)
      |-> demand_out.speed_pct <= $past(throttle_in.speed_pct))
    else $error("demand above throttle");
  chk_unmapped: assert property (
    psel_in && penable_in && paddr_in > 12'h030
      |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (
    psel_in && penable_in && paddr_in <= 12'h030 && paddr_in[1:0] == 2'h0
      |-> !pslverr_out)
    else $error("mapped access refused");
  cov_wake: cover property ($rose(wake_out));
  cov_boot_end: cover property ($rose(motion_ctrl_out) && wake_out);
  cov_irq_clear: cover property ($fell(irq_out));
endmodule

bind dlmtg_top dlmtg_top_chk #(.BOOT_CYCLES(BOOT_CYCLES)) dlmtg_top_chk_i (
  .clock_in, .rst_n_in, .clk_en_in, .psel_in, .penable_in, .paddr_in,
  .prdata_out, .pslverr_out, .key_on_in, .brake_released_in,
  .vehicle_speed_in, .throttle_in, .other_limit_in, .demand_out,
  .speed_cap_out, .current_limit_out, .wake_out, .motion_ctrl_out,
  .irq_out);

/* tb/tb.sv */
`include "dlmtg_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dlmtg_pkg::*;
  localparam int BOOT = 20;
  localparam int SEC  = 4;
  logic          clk, rst_n, clk_en, psel, penable, pwrite, pready;
  logic          pslverr, err_seen, key_on, brake_rel, batt;
  logic          wake, motion, irq;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [15:0]   wiper_ohm;
  logic [7:0]    amp_req, amp, peak, other, climit;
  logic [6:0]    speed, cap;
  dlmtg_demand_t thr, dem;
  int            errors, samples_checked, cycles, n;

  dlmtg_top #(.BOOT_CYCLES(BOOT), .SEC_CYCLES(SEC)) dlmtg_top_i (
    .clock_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .key_on_in(key_on),
    .brake_released_in(brake_rel), .battery_ok_in(batt),
    .vehicle_speed_in(speed), .throttle_in(thr), .wiper_ohm_in(wiper_ohm),
    .motor_amp_in(amp), .peak_limit_in(peak), .other_limit_in(other),
    .demand_out(dem), .speed_cap_out(cap), .current_limit_out(climit),
    .wake_out(wake), .motion_ctrl_out(motion), .irq_out(irq));
  dlmtg_stage_model dlmtg_stage_model_i (.clock_in(clk),
    .amp_req_in(amp_req), .current_limit_in(climit), .motor_amp_out(amp));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // held until pready is sampled high, released at that same edge, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string what, input logic [11:0] a,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic wcase(input logic [31:0] ctl, input logic [31:0] cfg,
    input logic [15:0] ohm, input logic rev, input logic [6:0] ed, ec);
    apb(1'b1, `DLMTG_A_CTRL, ctl);
    apb(1'b1, `DLMTG_A_WIPER, cfg);
    wiper_ohm <= ohm;
    thr       <= {7'h50, rev};
    repeat (3) @(posedge clk);
    check("demand", dem.speed_pct, ed);
    check("cap", cap, ec);
  endtask

  task automatic await_limit(input logic [7:0] target);
    n = 0;
    while (climit !== target && n < 60)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  initial
  begin
    {errors, samples_checked, cycles} = '0;
    {rst_n, psel, penable, pwrite, paddr, pwdata, brake_rel} = '0;
    {speed, thr, amp_req} = '0;
    {clk_en, key_on, batt} = '1;
    wiper_ohm = 16'h2710;
    peak      = 8'h32;
    other     = 8'hC8;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc("roll", `DLMTG_A_ROLL, 32'h28);
    rdc("wiper", `DLMTG_A_WIPER, 32'h32323232);
    rdc("oem spd", `DLMTG_A_OEM_SPD, 32'h64640000);
    rdc("oem acc", `DLMTG_A_OEM_ACC, 32'h6464);
    rdc("motor", `DLMTG_A_MOTOR, 32'h140C);
    rdc("cool", `DLMTG_A_COOL, 32'h20);
    apb(1'b0, 12'h040, 32'h0);
    check("unmapped", {rd[31:1], err_seen}, 32'h1);
    clk_en <= 1'b0;
    apb(1'b1, `DLMTG_A_ROLL, 32'h32);
    clk_en <= 1'b1;
    rdc("frozen write", `DLMTG_A_ROLL, 32'h28);
    $display("defaults done");
    apb(1'b1, `DLMTG_A_OEM_SPD, 32'h50460503);
    apb(1'b1, `DLMTG_A_DEALER0, 32'h5A3C0403);
    rdc("dealer0", `DLMTG_A_DEALER0, 32'h643C0003);
    rdc("reject flag", `DLMTG_A_IRQ_STAT, 32'h2);
    check("irq masked", irq, 1'b0);
    apb(1'b1, `DLMTG_A_IRQ_MASK, 32'hF);
    check("irq raised", irq, 1'b1);
    apb(1'b1, `DLMTG_A_IRQ_STAT, 32'h2);
    check("irq cleared", irq, 1'b0);
    apb(1'b1, `DLMTG_A_DEALER0, 32'h50460503);
    rdc("dealer0 edge", `DLMTG_A_DEALER0, 32'h50460503);
    rdc("no reject", `DLMTG_A_IRQ_STAT, 32'h0);
    apb(1'b1, `DLMTG_A_OEM_ACC, 32'h3C32);
    apb(1'b1, `DLMTG_A_DEALER1, 32'h37465A28);
    rdc("dealer1", `DLMTG_A_DEALER1, 32'h373C3228);
    $display("bounds done");
    // dealer maxima now 80 forward and 70 reverse, so caps never reach 100
    wcase(32'h0, 32'h1964643C, 16'h0, 1'b0, 7'h50, 7'h50);
    wcase(32'h1, 32'h1964643C, 16'h0, 1'b0, 7'h50, 7'h3C);
    wcase(32'h1, 32'h1964643C, 16'h0, 1'b1, 7'h14, 7'h46);
    wcase(32'h1, 32'h64326464, 16'h0, 1'b0, 7'h28, 7'h50);
    wcase(32'h1, 32'h64326464, 16'h2710, 1'b0, 7'h50, 7'h50);
    $display("wiper done");
    apb(1'b1, `DLMTG_A_MOTOR, 32'h020A);
    apb(1'b1, `DLMTG_A_COOL, 32'h1);
    apb(1'b1, `DLMTG_A_CTRL, 32'h2);
    check("limit", climit, 8'h32);
    other <= 8'h14;
    repeat (2) @(posedge clk);
    check("limit other", climit, 8'h14);
    other <= 8'hC8;
    amp_req <= 8'h32;
    await_limit(8'h0A);
    check("fast trip", n >= 8 && n <= 14, 1'b1);
    repeat (20) @(posedge clk);
    check("held at cont", climit, 8'h0A);
    rdc("trip flag", `DLMTG_A_IRQ_STAT, 32'h4);
    amp_req <= 8'h05;
    await_limit(8'h32);
    check("restore", n >= 5 && n <= 10, 1'b1);
    rdc("restore flag", `DLMTG_A_IRQ_STAT, 32'hC);
    apb(1'b1, `DLMTG_A_IRQ_STAT, 32'hF);
    apb(1'b1, `DLMTG_A_CTRL, 32'h0);
    apb(1'b1, `DLMTG_A_CTRL, 32'h2);
    amp_req <= 8'h1E;
    await_limit(8'h0A);
    check("slow trip", n >= 17 && n <= 22, 1'b1);
    apb(1'b1, `DLMTG_A_CTRL, 32'h0);
    amp_req <= 8'h32;
    repeat (40) @(posedge clk);
    check("disabled", climit, 8'h32);
    apb(1'b1, `DLMTG_A_IRQ_STAT, 32'hF);
    $display("thermal done");
    amp_req   <= 8'h00;
    key_on    <= 1'b0;
    brake_rel <= 1'b1;
    batt      <= 1'b0;
    speed     <= 7'h28;
    repeat (10) @(posedge clk);
    check("no wake at limit", wake, 1'b0);
    speed <= 7'h29;
    repeat (3) @(posedge clk);
    check("wake", wake, 1'b1);
    check("boot idle", motion, 1'b0);
    check("boot demand", dem.speed_pct, 7'h50);
    n = 0;
    while (motion !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    check("boot length", n >= 16 && n <= 21, 1'b1);
    repeat (2) @(posedge clk);
    check("guard demand", dem.speed_pct, 7'h00);
    check("guard cap", cap, 7'h28);
    rdc("wake flag", `DLMTG_A_IRQ_STAT, 32'h1);
    rdc("status", `DLMTG_A_STATUS, 32'h6);
    rdc("limits", `DLMTG_A_LIMITS, 32'h1928);
    key_on <= 1'b1;
    repeat (3) @(posedge clk);
    check("guard exit", wake, 1'b0);
    $display("rollaway done");
    tally_and_finish();
  end
endmodule
